//--- sim/ptt_timer_asserts.sv
// Checker on the ports of ptt_timer: bus timing, reset state, interrupt gating.
// Assumes it is bound to every ptt_timer; only the hclk domain is watched.
`timescale 1ns/1ps
module ptt_timer_asserts
  import ptt_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ref_clk,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic special_mode,
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic debug_halt,
  input wire logic tick_irq
);
  wire logic tk = hsel && hready && htrans == HTRANS_NONSEQ;
  logic wc_r;
  logic ien_r;
  // Enable bit as last written; masked writes leave it alone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wc_r <= 1'b0;
      ien_r <= 1'b0;
    end else begin
      wc_r <= tk && hwrite && haddr[ADDR_W-1:0] == CTL_ADDR;
      if (wc_r && !hwdata[MASK_BIT]) begin
        ien_r <= hwdata[IEN_BIT];
      end
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_rd;
    tk && !hwrite;
  endsequence
  sequence s_rd_ans;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_rd_wait; s_rd |=> s_rd_ans; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_wr_fast; tk && hwrite |=> hreadyout; endproperty
  a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
  property p_one_low; !hreadyout |=> hreadyout; endproperty
  a_one_low: assert property (p_one_low) else $error("long stall");
  property p_low_why; $fell(hreadyout) |-> $past(tk) && !$past(hwrite); endproperty
  a_low_why: assert property (p_low_why) else $error("stall without read");
  property p_hi_zero; hrdata[31:8] == 24'h00_0000; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
  property p_hold; $past(hreadyout) && hreadyout |-> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_okay; hresp == HRESP_OKAY; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_rst; $rose(hresetn) |-> hreadyout && !tick_irq && hrdata == 32'h0000_0000; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_irq_en; !ien_r [*2] |-> !tick_irq; endproperty
  a_irq_en: assert property (p_irq_en) else $error("request while disabled");
  property p_irq_fall; $fell(tick_irq) |-> $past(wc_r) || $past(wc_r, 2); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("request dropped alone");
endmodule : ptt_timer_asserts

bind ptt_timer ptt_timer_asserts i_chk (
  .hclk, .hresetn, .ref_clk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
  .hreadyout, .hrdata, .hresp, .special_mode, .wait_mode, .stop_mode, .debug_halt, .tick_irq
);

//--- sim/tb.sv
// Self-checking bench for ptt_timer: register rules, tick periods, low-power modes.
// Assumes the design and checker are compiled first; ref_clk is made here.
`timescale 1ns/1ps
module tb;
  import ptt_pkg::*;
  logic hclk, ref_clk, hresetn, hsel, hwrite, spec, wai, stp, dbg;
  logic hreadyout, hresp, tick_irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int failures, comparisons, cyc;
  always #5 hclk = ~hclk;
  // 14 ns period, no fixed phase to hclk
  always #7 ref_clk = ~ref_clk;
  always @(posedge hclk) cyc <= cyc + 1;
  ptt_timer i_dut (.hclk, .hresetn, .ref_clk, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .special_mode(spec),
    .wait_mode(wai), .stop_mode(stp), .debug_halt(dbg), .tick_irq);
  task automatic end_sim;
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic til(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (s !== v && n < lim);
    if (s !== v) begin
      failures++;
      end_sim();
    end
  endtask : til
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    til(hreadyout, 1'b1, 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    til(hreadyout, 1'b1, 20);
    rd = hrdata;
  endtask : bus
  task automatic rc(input logic [9:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask : rc
  task automatic t_regs;
    rc(CTL_ADDR, 32'h0000_0000);
    rc(CNT_ADDR, 32'h0000_0000);
    bus(1'b1, 10'h0f8, 8'hff);
    rc(10'h0f8, 32'h0000_0000);
    bus(1'b1, CTL_ADDR, 8'h3b);
    rc(CTL_ADDR, 32'h0000_0000);
    bus(1'b1, CTL_ADDR, 8'h94);
    rc(CTL_ADDR, 32'h0000_0014);
    bus(1'b1, CTL_ADDR, 8'h0c);
    rc(CTL_ADDR, 32'h0000_0014);
    bus(1'b1, CTL_ADDR, 8'h60);
    rc(CTL_ADDR, 32'h0000_0054);
    bus(1'b1, CTL_ADDR, 8'h14);
    rc(CTL_ADDR, 32'h0000_0054);
    spec <= 1'b1;
    bus(1'b1, CTL_ADDR, 8'h08);
    rc(CTL_ADDR, 32'h0000_0008);
    // Control writes share the lock; let it run out before the first count write
    repeat (20) @(posedge hclk);
    bus(1'b1, CNT_ADDR, 8'h09);
    bus(1'b1, CNT_ADDR, 8'h33);
    rc(CNT_ADDR, 32'h0000_0009);
    repeat (20) @(posedge hclk);
    bus(1'b1, CNT_ADDR, 8'h33);
    rc(CNT_ADDR, 32'h0000_0033);
  endtask : t_regs
  // Clear the flag, then wait for the next time-out
  task automatic nxt(input logic [1:0] rt);
    bus(1'b1, CTL_ADDR, {6'h21, rt});
    til(tick_irq, 1'b0, 10);
    til(tick_irq, 1'b1, 900);
  endtask : nxt
  task automatic t_per(input logic [1:0] rt, input logic [7:0] c, input int r);
    int t1, p;
    p = (c + 1) * r * 14 / 10;
    // Turn the timer off first, so the new count never runs at the old rate
    repeat (20) @(posedge hclk);
    bus(1'b1, CTL_ADDR, 8'h80);
    repeat (400) @(posedge hclk);
    bus(1'b1, CNT_ADDR, c);
    repeat (20) @(posedge hclk);
    nxt(rt);
    nxt(rt);
    t1 = cyc;
    nxt(rt);
    chk(32'(cyc - t1 > p - 3 && cyc - t1 < p + 3), 32'h0000_0001);
  endtask : t_per
  // Watch 100 cycles for a request under the given control byte and modes
  task automatic t_run(input logic [7:0] ctl, input logic w, s, d, input logic run);
    logic seen;
    seen = 1'b0;
    wai <= w;
    stp <= s;
    dbg <= d;
    bus(1'b1, CTL_ADDR, ctl);
    repeat (20) @(posedge hclk);
    bus(1'b1, CTL_ADDR, ctl);
    repeat (100) begin
      @(posedge hclk);
      seen = seen | tick_irq;
    end
    chk({31'h0, seen}, {31'h0, run});
  endtask : t_run
  initial begin
    {hclk, ref_clk, hresetn, hsel, hwrite, spec, wai, stp, dbg} = '0;
    {haddr, hwdata, htrans, failures, comparisons, cyc} = '0;
    hsize = 3'h2;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    // Fastest rate last, so the mode scenarios below see a short period
    t_per(2'h3, 8'h00, RATIO256);
    t_per(2'h2, 8'h01, RATIO16);
    t_per(2'h1, 8'h09, 1);
    bus(1'b1, CNT_ADDR, 8'h09);
    t_run(8'h95, 1'b1, 1'b0, 1'b0, 1'b0);
    t_run(8'h85, 1'b1, 1'b0, 1'b0, 1'b1);
    t_run(8'h85, 1'b0, 1'b1, 1'b0, 1'b0);
    t_run(8'h8d, 1'b0, 1'b1, 1'b0, 1'b1);
    t_run(8'hc5, 1'b0, 1'b0, 1'b1, 1'b0);
    t_run(8'h85, 1'b0, 1'b0, 1'b1, 1'b1);
    t_run(8'h81, 1'b0, 1'b0, 1'b0, 1'b0);
    rc(CTL_ADDR, 32'h0000_0081);
    bus(1'b1, CTL_ADDR, 8'h01);
    rc(CTL_ADDR, 32'h0000_0081);
    // Rate off only takes hold at the end of the running period, which still ticks
    repeat (20) @(posedge hclk);
    bus(1'b1, CTL_ADDR, 8'h04);
    repeat (40) @(posedge hclk);
    t_run(8'h84, 1'b0, 1'b0, 1'b0, 1'b0);
    bus(1'b1, CNT_ADDR, 8'h00);
    repeat (20) @(posedge hclk);
    t_run(8'h85, 1'b0, 1'b0, 1'b0, 1'b0);
    end_sim();
  end
endmodule : tb

//--- src/ptt_core.sv
// Reference-clock side: prescaler, modulus down counter and configuration capture.
// Assumes cfg_rate and cfg_count stay still while cfg_req_tgl differs from cfg_ack_tgl.
`timescale 1ns/1ps
module ptt_core
  import ptt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic hresetn,
  input wire logic cfg_req_tgl,
  input wire logic [RATE_W-1:0] cfg_rate,
  input wire logic [CNT_W-1:0] cfg_count,
  input wire logic [2:0] ctl_lvl,
  input wire logic [2:0] mode_lvl,
  output logic cfg_ack_tgl,
  output logic tout_tgl
);

  typedef struct packed {
    logic req_seen;
    logic ack;
    logic tout;
    logic pend;
    logic [RATE_W-1:0] new_rate;
    logic [CNT_W-1:0] new_cnt;
    logic [RATE_W-1:0] rate;
    logic [CNT_W-1:0] cnt;
    logic [7:0] pre;
    logic [CNT_W-1:0] modc;
  } ptt_core_s;

  ptt_core_s s_r;
  ptt_core_s s_nxt;
  logic rst_ref_n;
  logic req_s;
  logic [5:0] lvl_s;
  logic frz_en;
  logic wstop;
  logic srun;
  logic in_wait;
  logic in_stop;
  logic in_halt;
  logic off_act;

  // Reset asserts at once, releases on the reference clock
  ptt_sync #(.W(1)) u_rst_sync (
    .clk(ref_clk),
    .rst_n(hresetn),
    .d(1'b1),
    .q(rst_ref_n)
  );

  ptt_sync #(.W(7)) u_in_sync (
    .clk(ref_clk),
    .rst_n(rst_ref_n),
    .d({cfg_req_tgl, ctl_lvl, mode_lvl}),
    .q({req_s, lvl_s})
  );

  assign {frz_en, wstop, srun} = lvl_s[5:3];
  assign {in_wait, in_stop, in_halt} = lvl_s[2:0];

  function automatic logic [7:0] pre_reload(input logic [RATE_W-1:0] r);
    case (r)
      RATE_DIV16: pre_reload = 8'(RATIO16 - 1);
      RATE_DIV256: pre_reload = 8'(RATIO256 - 1);
      default: pre_reload = 8'h00;
    endcase
  endfunction : pre_reload

  always_comb begin
    s_nxt = s_r;
    // Bus side holds the words still until the ack returns
    if (req_s != s_r.req_seen) begin
      s_nxt.req_seen = req_s;
      s_nxt.ack = ~s_r.ack;
      s_nxt.new_rate = cfg_rate;
      s_nxt.new_cnt = cfg_count;
      s_nxt.pend = 1'b1;
    end
    off_act = (s_r.rate == RATE_OFF)
      || (s_r.rate == RATE_DIV1 && s_r.cnt == CNT_RST);
    if (off_act) begin
      if (s_nxt.pend) begin
        s_nxt.rate = s_nxt.new_rate;
        s_nxt.cnt = s_nxt.new_cnt;
        s_nxt.pre = pre_reload(s_nxt.new_rate);
        s_nxt.modc = s_nxt.new_cnt;
        s_nxt.pend = 1'b0;
      end
    end else if (in_wait && wstop) begin
      s_nxt.pre = pre_reload(s_r.rate);
      s_nxt.modc = s_r.cnt;
    end else if ((in_halt && frz_en) || (in_stop && !srun)) begin
      s_nxt.pre = s_r.pre;
    end else if (s_r.pre != 8'h00) begin
      s_nxt.pre = s_r.pre - 8'h01;
    end else if (s_r.modc != CNT_RST) begin
      s_nxt.modc = s_r.modc - 8'h01;
      s_nxt.pre = pre_reload(s_r.rate);
    end else begin
      s_nxt.tout = ~s_r.tout;
      if (s_nxt.pend) begin
        s_nxt.rate = s_nxt.new_rate;
        s_nxt.cnt = s_nxt.new_cnt;
        s_nxt.pend = 1'b0;
      end
      s_nxt.pre = pre_reload(s_nxt.rate);
      s_nxt.modc = s_nxt.cnt;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_ref_n) begin
    if (!rst_ref_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cfg_ack_tgl = s_r.ack;
  assign tout_tgl = s_r.tout;

endmodule : ptt_core

//--- src/ptt_pkg.sv
// Constants, register map and field layout of the periodic tick interrupt timer.
// Assumes a 32-bit AHB-Lite bus clock and a separate, asynchronous reference clock.
// Contract
// - Reference clock drives prescaler and down counter; each period end sets flag, restarts.
// - Counter and registers sit in separate clock domains; every crossing is synchronised.
// - Rate select zero, or ratio 1 with count 0, holds the counter stopped; other values let it run.
// - Interrupt request is flag AND enable bit 2; enable writable any time.
// - Wait-stop bit 4 one stops and reinitialises the counter in wait mode.
// - Stop-run bit 3 zero holds the counter static in stop mode.
// - Flag bit 7 set by hardware, cleared by writing one, never set by software.
// - Freeze bit 6 freezes counter in debug halt; normal modes only set it.
// - Write carrying bit 5 leaves bits 7 and 4..0 alone, consumes no write-once.
// - Normal modes: only first write to bits 4 and 3 counts; special: always.
// - Bits 1..0 select prescaler ratio; with count they set the period; lockout applies.
// - No external pins; control only through two registers and the interrupt line.
// - Period is (count+1) times ratio; codes select off,1,16,256; count 0 ratio 1 off.
// - Off-to-running starts a full period at once; running changes load at period end.
// - A write locks its item for three reference plus two bus cycles; writes then ignored. Rate and count share one lock here.
package ptt_pkg;

  localparam int ADDR_W = 10;
  // Printed offsets are register indices; the byte address is four times the index
  localparam logic [7:0] CTL_IDX = 8'h3c;
  localparam logic [7:0] CNT_IDX = 8'h3d;
  localparam logic [ADDR_W-1:0] CTL_ADDR = {CTL_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] CNT_ADDR = {CNT_IDX, 2'b00};

  localparam int FLAG_BIT = 7;
  localparam int FRZ_BIT = 6;
  localparam int MASK_BIT = 5;
  localparam int WSTOP_BIT = 4;
  localparam int SRUN_BIT = 3;
  localparam int IEN_BIT = 2;
  localparam int RATE_LSB = 0;
  localparam int RATE_W = 2;
  localparam int CNT_W = 8;

  localparam logic [RATE_W-1:0] RATE_OFF = 2'h0;
  localparam logic [RATE_W-1:0] RATE_DIV1 = 2'h1;
  localparam logic [RATE_W-1:0] RATE_DIV16 = 2'h2;
  localparam logic [RATE_W-1:0] RATE_DIV256 = 2'h3;
  localparam int RATIO16 = 16;
  localparam int RATIO256 = 256;

  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage : ptt_pkg

//--- src/ptt_sync.sv
// Two-flop level synchroniser, one per bit, vector wide.
// Assumes d is quasi-static relative to clk or is a toggle/level, never a pulse.
`timescale 1ns/1ps
module ptt_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } ptt_sync_s;

  ptt_sync_s s_r;
  ptt_sync_s s_nxt;

  // First stage feeds only the second stage
  always_comb begin
    s_nxt.meta = d;
    s_nxt.stab = s_r.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.stab;

endmodule : ptt_sync

//--- src/ptt_timer.sv
// Top of the periodic tick interrupt timer: AHB-Lite register slave on hclk and the
// reference-clock counter core. Assumes mode inputs are levels from logic on hclk.
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
module ptt_timer
  import ptt_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ref_clk,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic special_mode,
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic debug_halt,
  output logic tick_irq
);

  typedef struct packed {
    logic rd_pend;
    logic wr_pend;
    logic sel_ctl;
    logic sel_cnt;
    logic rdy;
    logic [31:0] rdata;
    logic flag;
    logic frz;
    logic wstop;
    logic srun;
    logic ien;
    logic [RATE_W-1:0] rate;
    logic [CNT_W-1:0] cnt;
    logic once;
    logic req;
    logic tout_seen;
    logic irq;
  } ptt_top_s;

  ptt_top_s s_r;
  ptt_top_s s_nxt;
  logic ack_tgl;
  logic tout_tgl;
  logic ack_s;
  logic tout_s;
  logic take;
  logic busy;
  logic [7:0] wd;
  logic [7:0] ctl_view;

  ptt_core u_core (
    .ref_clk(ref_clk),
    .hresetn(hresetn),
    .cfg_req_tgl(s_r.req),
    .cfg_rate(s_r.rate),
    .cfg_count(s_r.cnt),
    .ctl_lvl({s_r.frz, s_r.wstop, s_r.srun}),
    .mode_lvl({wait_mode, stop_mode, debug_halt}),
    .cfg_ack_tgl(ack_tgl),
    .tout_tgl(tout_tgl)
  );

  ptt_sync #(.W(2)) u_back_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .d({ack_tgl, tout_tgl}),
    .q({ack_s, tout_s})
  );

  // Width of hsize is ignored: every register is a word and data sit in the low byte
  assign take = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign busy = (s_r.req != ack_s);
  assign wd = hwdata[7:0];
  assign ctl_view = {s_r.flag, s_r.frz, 1'b0, s_r.wstop, s_r.srun, s_r.ien, s_r.rate};

  always_comb begin
    s_nxt = s_r;
    s_nxt.rd_pend = 1'b0;
    s_nxt.wr_pend = 1'b0;
    s_nxt.rdy = 1'b1;
    if (take) begin
      s_nxt.sel_ctl = (haddr[ADDR_W-1:0] == CTL_ADDR);
      s_nxt.sel_cnt = (haddr[ADDR_W-1:0] == CNT_ADDR);
      s_nxt.rd_pend = !hwrite;
      s_nxt.wr_pend = hwrite;
      // Reads take one wait state so hrdata can come from a register
      s_nxt.rdy = hwrite;
    end
    if (s_r.rd_pend) begin
      s_nxt.rdata = 32'h0000_0000;
      if (s_r.sel_ctl) begin
        s_nxt.rdata[7:0] = ctl_view;
      end else if (s_r.sel_cnt) begin
        s_nxt.rdata[CNT_W-1:0] = s_r.cnt;
      end
    end
    if (s_r.wr_pend && s_r.sel_ctl) begin
      s_nxt.frz = special_mode ? wd[FRZ_BIT] : (s_r.frz | wd[FRZ_BIT]);
      if (!wd[MASK_BIT]) begin
        s_nxt.flag = s_r.flag & ~wd[FLAG_BIT];
        s_nxt.ien = wd[IEN_BIT];
        if (special_mode || !s_r.once) begin
          s_nxt.wstop = wd[WSTOP_BIT];
          s_nxt.srun = wd[SRUN_BIT];
          s_nxt.once = 1'b1;
        end
        if (!busy) begin
          s_nxt.rate = wd[RATE_LSB +: RATE_W];
          s_nxt.req = ~s_r.req;
        end
      end
    end
    if (s_r.wr_pend && s_r.sel_cnt && !busy) begin
      s_nxt.cnt = wd[CNT_W-1:0];
      s_nxt.req = ~s_r.req;
    end
    // A timeout in the same cycle as a clearing write still sets the flag
    s_nxt.tout_seen = tout_s;
    if (tout_s != s_r.tout_seen) begin
      s_nxt.flag = 1'b1;
    end
    s_nxt.irq = s_nxt.flag && s_nxt.ien;
  end

  // Reset leaves the timer off, the flag clear and requests disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      s_r.rdy <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout = s_r.rdy;
  assign hrdata = s_r.rdata;
  assign hresp = HRESP_OKAY;
  assign tick_irq = s_r.irq;

endmodule : ptt_timer
